//--- common/cfb_pkg.sv
// Purpose: Constants and types shared by the configuration fuse bank.
// Assumes: AXI4-Lite with 32-bit data, one register per aligned word.
// Notes: Fuse registers sit at byte address four times their index.
//
// Functional notes
// - First low byte at index 300000h: debug 7, extended ISA 6, stack fault 5, watchdog 0.
// - First high byte at index 300001h: only code protection in bit 2.
// - Second low byte at 300002h: two-speed 7, monitor 6, default select 2, osc 1:0.
// - Unimplemented configuration bits always read back as zero.
// - Implemented bits read one when unprogrammed and accept one write only.
// - Code protection bit zero protects program memory; one leaves it open.
// - Two-speed start-up bit one enables oscillator switchover at start-up.
// - Monitor enable bit one turns on the fail-safe clock monitor.
// - Default select one with runtime select 00 uses the selected oscillator.
// - Oscillator code 11: external clock, soft multiplier, clock out on second pin.
// - Oscillator code 10: external clock, soft multiplier, no clock out.
// - Default select zero with runtime select 00 runs from internal oscillator.
// - Oscillator code 01: high-speed crystal with soft multiplier.
`default_nettype none
package cfb_pkg;
    // Register indices and their byte addresses.
    localparam logic [23:0] CFB_IDX_ONE_LOW = 24'h300000;
    localparam logic [23:0] CFB_IDX_ONE_HIGH = 24'h300001;
    localparam logic [23:0] CFB_IDX_TWO_LOW = 24'h300002;
    localparam logic [23:0] CFB_IDX_CONTROL = 24'h300004;
    localparam logic [23:0] CFB_IDX_STATUS = 24'h300005;
    localparam logic [31:0] CFB_ADDR_ONE_LOW = {6'h00, CFB_IDX_ONE_LOW, 2'h0};
    localparam logic [31:0] CFB_ADDR_ONE_HIGH = {6'h00, CFB_IDX_ONE_HIGH, 2'h0};
    localparam logic [31:0] CFB_ADDR_TWO_LOW = {6'h00, CFB_IDX_TWO_LOW, 2'h0};
    localparam logic [31:0] CFB_ADDR_CONTROL = {6'h00, CFB_IDX_CONTROL, 2'h0};
    localparam logic [31:0] CFB_ADDR_STATUS = {6'h00, CFB_IDX_STATUS, 2'h0};

    // Implemented-bit masks; an unprogrammed byte reads back as its mask.
    localparam logic [7:0] CFB_MASK_ONE_LOW = 8'hE1;
    localparam logic [7:0] CFB_MASK_ONE_HIGH = 8'h04;
    localparam logic [7:0] CFB_MASK_TWO_LOW = 8'hC7;

    // Field positions.
    localparam int CFB_BIT_DEBUG = 7;
    localparam int CFB_BIT_XISA = 6;
    localparam int CFB_BIT_STACK = 5;
    localparam int CFB_BIT_WDT = 0;
    localparam int CFB_BIT_CODE_PROT = 2;
    localparam int CFB_BIT_TWO_SPEED = 7;
    localparam int CFB_BIT_FAILSAFE = 6;
    localparam int CFB_BIT_DEF_CLK = 2;
    localparam int CFB_CTRL_SOFT_WDT = 0;
    localparam int CFB_CTRL_RT_LO = 1;
    localparam int CFB_STAT_CP = 6;
    localparam int CFB_STAT_WDT = 5;
    localparam int CFB_STAT_SRC_LO = 3;

    // Reset value of the control register and bus responses.
    localparam logic [31:0] CFB_CTRL_RESET = 32'h00000000;
    localparam logic [1:0] CFB_RESP_OKAY = 2'h0;
    localparam logic [1:0] CFB_RESP_SLVERR = 2'h2;
    localparam logic [1:0] CFB_RESP_DECERR = 2'h3;

    // Oscillator selection codes.
    localparam logic [1:0] CFB_OSC_EXT_CLKOUT = 2'h3;
    localparam logic [1:0] CFB_OSC_EXT = 2'h2;
    localparam logic [1:0] CFB_OSC_HS = 2'h1;
    localparam logic [1:0] CFB_RT_PRIMARY = 2'h0;

    typedef enum logic [1:0] {
        CFB_SRC_INTERNAL = 2'h0,
        CFB_SRC_HS = 2'h1,
        CFB_SRC_EXT = 2'h3
    } cfb_clk_src_t;

    // Decoded option bits as held in the fuses.
    typedef struct packed {
        logic debug_enable;
        logic extended_isa_enable;
        logic stack_fault_reset_enable;
        logic watchdog_force_enable;
        logic code_protect_n;
        logic two_speed_startup_enable;
        logic failsafe_monitor_enable;
        logic default_clock_select;
        logic [1:0] osc_select;
    } cfb_option_t;

    // System clock choice handed to the clock generator.
    typedef struct packed {
        cfb_clk_src_t src;
        logic pll_soft_control;
        logic clock_out_function;
    } cfb_clock_t;
endpackage : cfb_pkg
`default_nettype wire

//--- hdl/cfb_fuse_cell.sv
// Purpose: One write-once configuration byte.
// Assumes: Reset stands for the erased, unprogrammed fuse state.
// Notes: Only bits set in the mask are implemented.
`timescale 1ns/1ps
`default_nettype none
module cfb_fuse_cell #(
    parameter logic [7:0] MASK = 8'hFF
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Program port.
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    // Fuse contents.
    output logic [7:0] value,
    output logic programmed
);
    typedef struct packed {
        logic [7:0] value;
        logic programmed;
    } cfb_cell_st_t;

    cfb_cell_st_t s;
    cfb_cell_st_t next_s;

    // A write lands only while the byte is still blank.
    always_comb begin
        next_s = s;
        if (wr_en && !s.programmed) begin
            next_s.value = wr_data & MASK;
            next_s.programmed = 1'b1;
        end
    end

    // Erased fuses read one on implemented bits, zero elsewhere.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s.value <= MASK;
            s.programmed <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    assign value = s.value;
    assign programmed = s.programmed;
endmodule : cfb_fuse_cell
`default_nettype wire

//--- hdl/cfb_config_fuse_bank.sv
// Purpose: Configuration fuse bank with AXI4-Lite access and decoded options.
// Assumes: One clock; synchronous active-low reset.
// Notes: Fuse writes are accepted once per byte; later writes get SLVERR.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cfb_config_fuse_bank (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Write address channel.
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_awaddr,
    // Write data channel.
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // Write response channel.
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // Read address channel.
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [31:0] s_axi_araddr,
    // Read data channel.
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Core stack events.
    input wire logic stack_overflow,
    input wire logic stack_underflow,
    // Option outputs.
    output cfb_pkg::cfb_option_t options,
    output cfb_pkg::cfb_clock_t sys_clock,
    output logic code_protected,
    output logic watchdog_run,
    output logic stack_fault_reset
);
    typedef enum logic {
        CFB_W_IDLE = 1'b0,
        CFB_W_RESP = 1'b1
    } cfb_wstate_t;

    typedef enum logic {
        CFB_R_IDLE = 1'b0,
        CFB_R_DATA = 1'b1
    } cfb_rstate_t;

    typedef enum logic [2:0] {
        CFB_SEL_ONE_LOW = 3'h0,
        CFB_SEL_ONE_HIGH = 3'h1,
        CFB_SEL_TWO_LOW = 3'h2,
        CFB_SEL_CONTROL = 3'h3,
        CFB_SEL_STATUS = 3'h4,
        CFB_SEL_NONE = 3'h7
    } cfb_sel_t;

    typedef struct packed {
        cfb_wstate_t wstate;
        logic aw_held;
        logic [31:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [1:0] bresp;
        cfb_rstate_t rstate;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic soft_wdt;
        logic [1:0] rt_sel;
        logic wdt_run;
        logic fault_rst;
        logic cp;
        cfb_pkg::cfb_clock_t clk;
    } cfb_main_st_t;

    cfb_main_st_t s;
    cfb_main_st_t next_s;

    logic [2:0] fuse_we;
    logic [2:0] fuse_done;
    logic [7:0] fuse_one_low;
    logic [7:0] fuse_one_high;
    logic [7:0] fuse_two_low;
    logic commit;
    cfb_sel_t wsel;
    cfb_sel_t rsel;

    // Maps a byte address onto a register; used by both channels.
    function automatic cfb_sel_t addr_decode(input logic [31:0] addr);
        unique case (addr)
            cfb_pkg::CFB_ADDR_ONE_LOW: addr_decode = CFB_SEL_ONE_LOW;
            cfb_pkg::CFB_ADDR_ONE_HIGH: addr_decode = CFB_SEL_ONE_HIGH;
            cfb_pkg::CFB_ADDR_TWO_LOW: addr_decode = CFB_SEL_TWO_LOW;
            cfb_pkg::CFB_ADDR_CONTROL: addr_decode = CFB_SEL_CONTROL;
            cfb_pkg::CFB_ADDR_STATUS: addr_decode = CFB_SEL_STATUS;
            default: addr_decode = CFB_SEL_NONE;
        endcase
    endfunction : addr_decode

    // Chooses the system clock from the fuses and the runtime select.
    function automatic cfb_pkg::cfb_clock_t clk_decode(
        input cfb_pkg::cfb_option_t opt,
        input logic [1:0] rt
    );
        cfb_pkg::cfb_clock_t c;
        c.src = cfb_pkg::CFB_SRC_INTERNAL;
        c.pll_soft_control = 1'b0;
        c.clock_out_function = 1'b0;
        if (rt == cfb_pkg::CFB_RT_PRIMARY && opt.default_clock_select) begin
            unique case (opt.osc_select)
                cfb_pkg::CFB_OSC_EXT_CLKOUT: begin
                    c.src = cfb_pkg::CFB_SRC_EXT;
                    c.pll_soft_control = 1'b1;
                    c.clock_out_function = 1'b1;
                end
                cfb_pkg::CFB_OSC_EXT: begin
                    c.src = cfb_pkg::CFB_SRC_EXT;
                    c.pll_soft_control = 1'b1;
                end
                cfb_pkg::CFB_OSC_HS: begin
                    c.src = cfb_pkg::CFB_SRC_HS;
                    c.pll_soft_control = 1'b1;
                end
                default: begin
                    c.src = cfb_pkg::CFB_SRC_HS;
                end
            endcase
        end
        clk_decode = c;
    endfunction : clk_decode

    // The three write-once configuration bytes.
    cfb_fuse_cell #(
        .MASK(cfb_pkg::CFB_MASK_ONE_LOW)
    ) u_one_low (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_en(fuse_we[0]),
        .wr_data(s.wdata[7:0]),
        .value(fuse_one_low),
        .programmed(fuse_done[0])
    );

    cfb_fuse_cell #(
        .MASK(cfb_pkg::CFB_MASK_ONE_HIGH)
    ) u_one_high (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_en(fuse_we[1]),
        .wr_data(s.wdata[7:0]),
        .value(fuse_one_high),
        .programmed(fuse_done[1])
    );

    cfb_fuse_cell #(
        .MASK(cfb_pkg::CFB_MASK_TWO_LOW)
    ) u_two_low (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_en(fuse_we[2]),
        .wr_data(s.wdata[7:0]),
        .value(fuse_two_low),
        .programmed(fuse_done[2])
    );

    // Fuse bits spread out into named options.
    assign options.debug_enable = fuse_one_low[cfb_pkg::CFB_BIT_DEBUG];
    assign options.extended_isa_enable = fuse_one_low[cfb_pkg::CFB_BIT_XISA];
    assign options.stack_fault_reset_enable = fuse_one_low[cfb_pkg::CFB_BIT_STACK];
    assign options.watchdog_force_enable = fuse_one_low[cfb_pkg::CFB_BIT_WDT];
    assign options.code_protect_n = fuse_one_high[cfb_pkg::CFB_BIT_CODE_PROT];
    assign options.two_speed_startup_enable = fuse_two_low[cfb_pkg::CFB_BIT_TWO_SPEED];
    assign options.failsafe_monitor_enable = fuse_two_low[cfb_pkg::CFB_BIT_FAILSAFE];
    assign options.default_clock_select = fuse_two_low[cfb_pkg::CFB_BIT_DEF_CLK];
    assign options.osc_select = fuse_two_low[1:0];

    // Handshake outputs follow the channel states directly.
    assign s_axi_awready = (s.wstate == CFB_W_IDLE) && !s.aw_held;
    assign s_axi_wready = (s.wstate == CFB_W_IDLE) && !s.w_held;
    assign s_axi_bvalid = (s.wstate == CFB_W_RESP);
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = (s.rstate == CFB_R_IDLE);
    assign s_axi_rvalid = (s.rstate == CFB_R_DATA);
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;

    // Registered decoded outputs.
    assign sys_clock = s.clk;
    assign code_protected = s.cp;
    assign watchdog_run = s.wdt_run;
    assign stack_fault_reset = s.fault_rst;

    // A write commits once both address and data are held.
    assign commit = (s.wstate == CFB_W_IDLE) && s.aw_held && s.w_held;
    assign wsel = addr_decode(s.awaddr);
    assign rsel = addr_decode(s_axi_araddr);

    // Only lane 0 carries a fuse byte; a blank lane leaves the fuse alone.
    always_comb begin
        fuse_we = 3'h0;
        if (commit && s.wstrb[0]) begin
            unique case (wsel)
                CFB_SEL_ONE_LOW: fuse_we[0] = 1'b1;
                CFB_SEL_ONE_HIGH: fuse_we[1] = 1'b1;
                CFB_SEL_TWO_LOW: fuse_we[2] = 1'b1;
                default: fuse_we = 3'h0;
            endcase
        end
    end

    // Next-state logic for the bus slave and the decoded outputs.
    always_comb begin
        next_s = s;

        // Address and data are taken independently, in either order.
        if (s_axi_awvalid && s_axi_awready) begin
            next_s.aw_held = 1'b1;
            next_s.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_s.w_held = 1'b1;
            next_s.wdata = s_axi_wdata;
            next_s.wstrb = s_axi_wstrb;
        end

        // Commit the write and choose its response.
        if (commit) begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.wstate = CFB_W_RESP;
            next_s.bresp = cfb_pkg::CFB_RESP_OKAY;
            unique case (wsel)
                CFB_SEL_ONE_LOW: begin
                    if (fuse_done[0]) next_s.bresp = cfb_pkg::CFB_RESP_SLVERR;
                end
                CFB_SEL_ONE_HIGH: begin
                    if (fuse_done[1]) next_s.bresp = cfb_pkg::CFB_RESP_SLVERR;
                end
                CFB_SEL_TWO_LOW: begin
                    if (fuse_done[2]) next_s.bresp = cfb_pkg::CFB_RESP_SLVERR;
                end
                CFB_SEL_CONTROL: begin
                    if (s.wstrb[0]) begin
                        next_s.soft_wdt = s.wdata[cfb_pkg::CFB_CTRL_SOFT_WDT];
                        next_s.rt_sel = s.wdata[cfb_pkg::CFB_CTRL_RT_LO +: 2];
                    end
                end
                CFB_SEL_STATUS: begin
                    next_s.bresp = cfb_pkg::CFB_RESP_SLVERR;
                end
                default: begin
                    next_s.bresp = cfb_pkg::CFB_RESP_DECERR;
                end
            endcase
        end

        // The response stands until the master takes it.
        if (s.wstate == CFB_W_RESP && s_axi_bready) begin
            next_s.wstate = CFB_W_IDLE;
        end

        // Read data are captured in the cycle the address is taken.
        if (s.rstate == CFB_R_IDLE && s_axi_arvalid) begin
            next_s.rstate = CFB_R_DATA;
            next_s.rdata = 32'h00000000;
            next_s.rresp = cfb_pkg::CFB_RESP_OKAY;
            unique case (rsel)
                CFB_SEL_ONE_LOW: next_s.rdata[7:0] = fuse_one_low;
                CFB_SEL_ONE_HIGH: next_s.rdata[7:0] = fuse_one_high;
                CFB_SEL_TWO_LOW: next_s.rdata[7:0] = fuse_two_low;
                CFB_SEL_CONTROL: begin
                    next_s.rdata[cfb_pkg::CFB_CTRL_SOFT_WDT] = s.soft_wdt;
                    next_s.rdata[cfb_pkg::CFB_CTRL_RT_LO +: 2] = s.rt_sel;
                end
                CFB_SEL_STATUS: begin
                    next_s.rdata[2:0] = fuse_done;
                    next_s.rdata[cfb_pkg::CFB_STAT_SRC_LO +: 2] = s.clk.src;
                    next_s.rdata[cfb_pkg::CFB_STAT_WDT] = s.wdt_run;
                    next_s.rdata[cfb_pkg::CFB_STAT_CP] = s.cp;
                end
                default: begin
                    next_s.rresp = cfb_pkg::CFB_RESP_DECERR;
                end
            endcase
        end else if (s.rstate == CFB_R_DATA && s_axi_rready) begin
            next_s.rstate = CFB_R_IDLE;
        end

        // Decoded device options, refreshed every cycle.
        next_s.cp = !options.code_protect_n;
        next_s.wdt_run = options.watchdog_force_enable || s.soft_wdt;
        next_s.fault_rst = options.stack_fault_reset_enable
            && (stack_overflow || stack_underflow);
        next_s.clk = clk_decode(options, s.rt_sel);
    end

    // State register; the control register resets to its defined value.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.soft_wdt <= cfb_pkg::CFB_CTRL_RESET[cfb_pkg::CFB_CTRL_SOFT_WDT];
            s.rt_sel <= cfb_pkg::CFB_CTRL_RESET[cfb_pkg::CFB_CTRL_RT_LO +: 2];
        end else begin
            s <= next_s;
        end
    end
endmodule : cfb_config_fuse_bank
`default_nettype wire

//--- test/cfb_fuse_bank_chk.sv
// Purpose: Port assertions for the configuration fuse bank.
// Assumes: One clock with a synchronous active-low reset.
// Notes: Read checks use the address taken.
`timescale 1ns/1ps
`default_nettype none
module cfb_fuse_bank_chk (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes.
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    // Core side.
    input wire logic stack_overflow,
    input wire logic stack_underflow,
    input wire cfb_pkg::cfb_option_t options,
    input wire cfb_pkg::cfb_clock_t sys_clock,
    input wire logic code_protected,
    input wire logic watchdog_run,
    input wire logic stack_fault_reset
);
    logic [31:0] rd_addr;
    // Keeps the address of the read in flight.
    always_ff @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            rd_addr <= s_axi_araddr;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Steps of a read answer and of a write acceptance.
    sequence rd_ok; s_axi_rvalid && s_axi_rresp == cfb_pkg::CFB_RESP_OKAY; endsequence
    sequence wr_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    low_unimpl_a: assert property (rd_ok |-> rd_addr != cfb_pkg::CFB_ADDR_ONE_LOW || (s_axi_rdata & 32'hFFFFFF1E) == 32'h0)
        else $error("one-low unimplemented bits set");
    high_unimpl_a: assert property (rd_ok |-> rd_addr != cfb_pkg::CFB_ADDR_ONE_HIGH || (s_axi_rdata & 32'hFFFFFFFB) == 32'h0)
        else $error("one-high unimplemented bits set");
    two_unimpl_a: assert property (rd_ok |-> rd_addr != cfb_pkg::CFB_ADDR_TWO_LOW || (s_axi_rdata & 32'hFFFFFF38) == 32'h0)
        else $error("two-low unimplemented bits set");
    code_prot_a: assert property ($fell(options.code_protect_n) |=> code_protected)
        else $error("program memory not protected");
    wdt_force_a: assert property (options.watchdog_force_enable |=> watchdog_run)
        else $error("forced watchdog not running");
    fault_set_a: assert property ((stack_overflow || stack_underflow) && options.stack_fault_reset_enable |=> stack_fault_reset)
        else $error("stack fault gave no reset");
    fault_clear_a: assert property (!(stack_overflow || stack_underflow) |=> !stack_fault_reset)
        else $error("reset without stack fault");
    src_internal_a: assert property (!options.default_clock_select |=> sys_clock.src == cfb_pkg::CFB_SRC_INTERNAL)
        else $error("internal oscillator not chosen");
    clk_out_a: assert property (sys_clock.clock_out_function |-> $past(options.osc_select) == 2'h3)
        else $error("clock out without code 11");
    wr_resp_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
endmodule : cfb_fuse_bank_chk
bind cfb_config_fuse_bank cfb_fuse_bank_chk chk_u (.*);
`default_nettype wire

//--- test/cfb_prog_model.sv
// Purpose: Programmer model that writes and reads configuration bytes.
// Assumes: One caller at a time.
// Notes: Released address and data lines show the inverse of their last value.
`timescale 1ns/1ps
`default_nettype none
module cfb_prog_model (
    // Clock.
    input wire logic aclk,
    // Write channels.
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_awaddr,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    // Read channels.
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    output logic [31:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    // Idle bus at time zero.
    initial begin
        s_axi_awvalid = 1'b0;
        s_axi_awaddr = 32'h0;
        s_axi_wvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_araddr = 32'h0;
        s_axi_rready = 1'b0;
    end
    // Offers address and data together and releases each once taken.
    task automatic write(input logic [31:0] a, input logic [31:0] d);
        logic aw_left, w_left, aw_hit, w_hit;
        aw_left = 1'b1;
        w_left = 1'b1;
        repeat ($urandom_range(2)) @(posedge aclk);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= (a == cfb_pkg::CFB_ADDR_ONE_HIGH) ? (d & 32'hFFFFFFF7) : d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw_left || w_left) begin
            @(negedge aclk);
            aw_hit = aw_left && s_axi_awready;
            w_hit = w_left && s_axi_wready;
            @(posedge aclk);
            if (aw_hit) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~s_axi_awaddr;
            end
            if (w_hit) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~s_axi_wdata;
            end
            aw_left = aw_left && !aw_hit;
            w_left = w_left && !w_hit;
        end
        do @(negedge aclk); while (!s_axi_bvalid);
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask : write
    // Reads one word and holds rready until the answer is taken.
    task automatic read(input logic [31:0] a);
        repeat ($urandom_range(2)) @(posedge aclk);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge aclk); while (!s_axi_arready);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        do @(negedge aclk); while (!s_axi_rvalid);
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask : read
endmodule : cfb_prog_model
`default_nettype wire

//--- test/test_config_fuse_bank.sv
// Purpose: Self-checking bench for the configuration fuse bank.
// Assumes: Reset erases the fuses.
// Notes: Bus answers are compared against queued expectations.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module test_config_fuse_bank;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, be;
    logic stack_overflow = 1'b0;
    logic stack_underflow = 1'b0;
    logic code_protected, watchdog_run, stack_fault_reset;
    cfb_pkg::cfb_option_t options;
    cfb_pkg::cfb_clock_t sys_clock;
    cfb_pkg::cfb_clk_src_t src;
    int err_total = 0;
    int num_checks = 0;
    logic [33:0] rexp[$];
    logic [33:0] re;
    logic [1:0] bexp[$];
    logic [7:0] fb [3];
    logic [31:0] fa [3] = '{cfb_pkg::CFB_ADDR_ONE_LOW, cfb_pkg::CFB_ADDR_ONE_HIGH, cfb_pkg::CFB_ADDR_TWO_LOW};
    logic [7:0] fm [3] = '{cfb_pkg::CFB_MASK_ONE_LOW, cfb_pkg::CFB_MASK_ONE_HIGH, cfb_pkg::CFB_MASK_TWO_LOW};
    cfb_config_fuse_bank dut_u (.*);
    cfb_prog_model prog_u (.*);
    // Clock of 4 ns period.
    always #2 aclk = ~aclk;
    // Pairs each bus answer with the oldest expectation at its handshake.
    always @(negedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            re = (rexp.size() != 0) ? rexp.pop_front() : {34{1'bx}};
            `CHK({s_axi_rresp, s_axi_rdata}, re)
        end
        if (s_axi_bvalid && s_axi_bready) begin
            be = (bexp.size() != 0) ? bexp.pop_front() : 2'bxx;
            `CHK(s_axi_bresp, be)
        end
    end
    // Bus accesses that note their expected answer first.
    task automatic rd(input logic [31:0] a, input logic [31:0] v, input logic [1:0] r);
        rexp.push_back({r, v});
        prog_u.read(a);
    endtask : rd
    task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] r);
        bexp.push_back(r);
        prog_u.write(a, v);
    endtask : wr
    // Holds reset for eight cycles.
    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
    endtask : do_reset
    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    // Ends a hung run.
    initial begin
        #100us;
        err_total++;
        finish_test();
    end
    // Erased state, then eight programming rounds over all clock codes.
    initial begin
        d = $urandom(32'hA51C);
        do_reset();
        for (int j = 0; j < 3; j++) begin
            rd(fa[j], {24'h0, fm[j]}, cfb_pkg::CFB_RESP_OKAY);
        end
        rd(cfb_pkg::CFB_ADDR_CONTROL, 32'h0, cfb_pkg::CFB_RESP_OKAY);
        rd(32'h00000040, 32'h0, cfb_pkg::CFB_RESP_DECERR);
        wr(32'h00000040, d, cfb_pkg::CFB_RESP_DECERR);
        wr(cfb_pkg::CFB_ADDR_STATUS, d, cfb_pkg::CFB_RESP_SLVERR);
        @(negedge aclk);
        `CHK(sys_clock, {cfb_pkg::CFB_SRC_EXT, 2'h3})
        `CHK(code_protected, 1'b0)
        `CHK(watchdog_run, 1'b1)
        $display("test erased done");
        for (int i = 0; i < 8; i++) begin
            do_reset();
            d = $urandom();
            fb[0] = {d[7:6], i[0], d[4:0]};
            fb[1] = {d[15:11], i[1], d[9:8]};
            fb[2] = {d[23:19], i[2:0]};
            for (int j = 0; j < 3; j++) begin
                wr(fa[j], {d[31:8], fb[j]}, cfb_pkg::CFB_RESP_OKAY);
            end
            wr(fa[i % 3], ~d, cfb_pkg::CFB_RESP_SLVERR);
            for (int j = 0; j < 3; j++) begin
                rd(fa[j], {24'h0, fb[j] & fm[j]}, cfb_pkg::CFB_RESP_OKAY);
            end
            repeat (3) @(negedge aclk);
            `CHK(code_protected, ~fb[1][2])
            `CHK(watchdog_run, fb[0][0])
            `CHK(options.extended_isa_enable, fb[0][6])
            `CHK(options.two_speed_startup_enable, fb[2][7])
            `CHK(options.failsafe_monitor_enable, fb[2][6])
            src = !i[2] ? cfb_pkg::CFB_SRC_INTERNAL : (i[1] ? cfb_pkg::CFB_SRC_EXT : cfb_pkg::CFB_SRC_HS);
            `CHK(sys_clock.src, src)
            if (i[2]) `CHK(sys_clock[1:0], {i[1] | i[0], i[1] & i[0]})
            @(posedge aclk);
            stack_overflow <= !i[1];
            stack_underflow <= i[1];
            @(posedge aclk);
            stack_overflow <= 1'b0;
            stack_underflow <= 1'b0;
            @(negedge aclk);
            `CHK(stack_fault_reset, fb[0][5])
            wr(cfb_pkg::CFB_ADDR_CONTROL, 32'h3, cfb_pkg::CFB_RESP_OKAY);
            rd(cfb_pkg::CFB_ADDR_CONTROL, 32'h3, cfb_pkg::CFB_RESP_OKAY);
            rd(cfb_pkg::CFB_ADDR_STATUS, {25'h0, ~fb[1][2], 3'h4, 3'h7}, cfb_pkg::CFB_RESP_OKAY);
            repeat (3) @(negedge aclk);
            `CHK(watchdog_run, 1'b1)
            `CHK(sys_clock.src, cfb_pkg::CFB_SRC_INTERNAL)
            $display("test %0d done", i);
        end
        finish_test();
    end
endmodule : test_config_fuse_bank
`default_nettype wire
